//--- common/stl_pkg.sv
// Package for the self-test and log read unit: constants, codes and states
package stl_pkg;
    // Register bus map (word aligned byte addresses)
    localparam logic [7:0] STL_ADDR_TASKFILE = 8'h00; // features, sector number, count
    localparam logic [7:0] STL_ADDR_TRACK    = 8'h04; // track address pair
    localparam logic [7:0] STL_ADDR_COMMAND  = 8'h08; // write: opcode; starts command
    localparam logic [7:0] STL_ADDR_STATUS   = 8'h0c; // busy, irq, abort, flags
    localparam logic [7:0] STL_ADDR_RESULTS  = 8'h10; // status bytes and span
    localparam logic [7:0] STL_ADDR_CONFIG   = 8'h14; // pending time, scan enable
    localparam logic [7:0] STL_ADDR_MEDIA    = 8'h18; // media scan report from drive
    localparam logic [7:0] STL_ADDR_DATA     = 8'h1c; // log data word read port

    // Command codes
    localparam logic [7:0]  STL_OPC_SMART     = 8'hb0;
    localparam logic [15:0] STL_TRACK_KEY     = 16'hc24f;
    localparam logic [7:0]  STL_FT_EXEC       = 8'hd4;
    localparam logic [7:0]  STL_FT_READ_LOG   = 8'hd5;

    // Execute subcommands
    localparam logic [7:0] STL_SUB_OFFLINE    = 8'h00;
    localparam logic [7:0] STL_SUB_SHORT_OFF  = 8'h01;
    localparam logic [7:0] STL_SUB_EXT_OFF    = 8'h02;
    localparam logic [7:0] STL_SUB_SEL_OFF    = 8'h04;
    localparam logic [7:0] STL_SUB_ABORT      = 8'h0f;
    localparam logic [7:0] STL_SUB_SHORT_CAP  = 8'h81;
    localparam logic [7:0] STL_SUB_EXT_CAP    = 8'h82;
    localparam logic [7:0] STL_SUB_SEL_CAP    = 8'h84;

    // Log addresses
    localparam logic [7:0] STL_LOG_DIR        = 8'h00;
    localparam logic [7:0] STL_LOG_EXT_ERR    = 8'h03;
    localparam logic [7:0] STL_LOG_SELFTEST   = 8'h06;
    localparam logic [7:0] STL_LOG_EXT_SELF   = 8'h07;
    localparam logic [7:0] STL_LOG_SELECTIVE  = 8'h09;
    localparam logic [7:0] STL_LOG_VEND_LO    = 8'h80;
    localparam logic [7:0] STL_LOG_VEND_HI    = 8'h9f;
    localparam logic [7:0] STL_LOG_VERSION    = 8'h01;
    localparam logic [7:0] STL_VEND_SECTORS   = 8'h10;
    localparam int         STL_SECTOR_BYTES   = 512;
    localparam int         STL_SECTOR_WORDS   = STL_SECTOR_BYTES / 4;

    // Status byte values
    localparam logic [7:0] STL_ST_OK          = 8'h00;
    localparam logic [7:0] STL_ST_ABORTED     = 8'h10;
    localparam logic [7:0] STL_ST_FAILED      = 8'h70;
    localparam logic [7:0] STL_ST_RUNNING     = 8'hf0;
    localparam logic [7:0] STL_OL_DONE        = 8'h02;
    localparam logic [7:0] STL_OL_SCANNING    = 8'h03;
    localparam logic [3:0] STL_SPAN_OFFLINE   = 4'h6;
    localparam logic [3:0] STL_SPAN_COUNT     = 4'h5;

    // Reset values of software settings
    localparam logic [15:0] STL_PEND_TIME_RST = 16'h0000;
    localparam int          STL_MS_NS         = 1000000;
    localparam int          STL_CLK_NS        = 10;
    localparam int          STL_MS_CYCLES     = STL_MS_NS / STL_CLK_NS;

    typedef enum logic [2:0] {
        STL_IDLE, STL_CAPTIVE, STL_SPANS, STL_PENDING, STL_OFFSCAN, STL_COLLECT, STL_SHORTEXT
    } stl_test_t;
endpackage

//--- verilog/stl_unit.sv
// Self-test sequencer and read-log command unit with an APB register port
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module stl_unit
    import stl_pkg::*;
#(
    parameter int MS_CYCLES = STL_MS_CYCLES
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        SOFT_RESET_IN,
    input  wire logic        NV_PENDING_IN,
    input  wire logic        NV_ACTIVE_IN,
    output logic             NV_PENDING_OUT,
    output logic             NV_ACTIVE_OUT,
    output logic             BUSY_OUT,
    output logic             INTRQ_OUT
);
    logic        soft_s1_q, soft_s2_q, soft_s3_q, nvp_s1_q, nvp_s2_q, nva_s1_q, nva_s2_q;
    logic [2:0]  boot_q;
    logic [7:0]  features_reg_q, sector_number_reg_q, count_reg_q;
    logic [15:0] track_address_pair_q;
    logic [15:0] pend_time_q;
    logic        scan_en_q;
    logic [7:0]  st_status_q, ol_status_q;
    logic [3:0]  span_q;
    logic        pending_q, active_q;
    logic        busy_q, intrq_q, abort_q, captive_q;
    logic        media_done_q, media_err_q;
    logic [7:0]  log_addr_q;
    logic [6:0]  word_idx_q;
    logic [31:0] ms_cnt_q;
    logic [15:0] delay_q;
    stl_test_t   state_q;

    wire wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
    wire rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    wire soft_rise = soft_s2_q & ~soft_s3_q;
    // Power-up check waits until the stored flags have crossed the synchroniser
    wire boot_now = boot_q[2];
    wire cmd_wr = wr_en && PADDR_IN == STL_ADDR_COMMAND;
    wire smart_ok = PWDATA_IN[7:0] == STL_OPC_SMART && track_address_pair_q == STL_TRACK_KEY;
    wire do_exec = cmd_wr && smart_ok && features_reg_q == STL_FT_EXEC;
    wire do_read = cmd_wr && smart_ok && features_reg_q == STL_FT_READ_LOG;
    wire bad_log = sector_number_reg_q == STL_LOG_EXT_ERR || sector_number_reg_q == STL_LOG_EXT_SELF;
    wire is_sel = sector_number_reg_q == STL_SUB_SEL_OFF || sector_number_reg_q == STL_SUB_SEL_CAP;
    wire is_capt = sector_number_reg_q[7];
    wire is_test = is_sel || sector_number_reg_q == STL_SUB_SHORT_OFF || sector_number_reg_q == STL_SUB_EXT_OFF
                || sector_number_reg_q == STL_SUB_SHORT_CAP || sector_number_reg_q == STL_SUB_EXT_CAP;
    wire data_rd = rd_en && PADDR_IN == STL_ADDR_DATA;

    // Sector count held by each log, used by the directory
    function automatic logic [7:0] log_sectors(input logic [7:0] addr);
        if (addr >= STL_LOG_VEND_LO && addr <= STL_LOG_VEND_HI)
            log_sectors = STL_VEND_SECTORS;
        else if (addr == STL_LOG_SELFTEST || addr == STL_LOG_SELECTIVE || addr == STL_LOG_DIR)
            log_sectors = 8'h01;
        else
            log_sectors = 8'h00;
    endfunction

    // Directory word: bytes 4i..4i+3; even bytes hold counts of logs 2i and 2i+1, except byte 0, which holds the log version
    function automatic logic [31:0] dir_word(input logic [6:0] idx);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = (idx == 7'h00) ? STL_LOG_VERSION : log_sectors({idx, 1'b0});
        hi = log_sectors({idx, 1'b1});
        dir_word = {8'h00, hi, 8'h00, lo};
    endfunction

    // Pin inputs pass two flops before use
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            {soft_s1_q, soft_s2_q, soft_s3_q} <= 3'h0;
            {nvp_s1_q, nvp_s2_q, nva_s1_q, nva_s2_q} <= 4'h0;
        end else begin
            soft_s1_q <= SOFT_RESET_IN;
            soft_s2_q <= soft_s1_q;
            soft_s3_q <= soft_s2_q;
            nvp_s1_q  <= NV_PENDING_IN;
            nvp_s2_q  <= nvp_s1_q;
            nva_s1_q  <= NV_ACTIVE_IN;
            nva_s2_q  <= nva_s1_q;
        end
    end

    // Task file and software settings
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            features_reg_q       <= 8'h00;
            sector_number_reg_q  <= 8'h00;
            track_address_pair_q <= 16'h0000;
            pend_time_q          <= STL_PEND_TIME_RST;
            scan_en_q            <= 1'b0;
            media_done_q         <= 1'b0;
            media_err_q          <= 1'b0;
        end else begin
            media_done_q <= 1'b0;
            media_err_q  <= 1'b0;
            if (wr_en && PADDR_IN == STL_ADDR_TASKFILE) begin
                features_reg_q      <= PWDATA_IN[7:0];
                sector_number_reg_q <= PWDATA_IN[15:8];
            end
            if (wr_en && PADDR_IN == STL_ADDR_TRACK)
                track_address_pair_q <= PWDATA_IN[15:0];
            // Settings are frozen while the selective spans run (STL_SPANS), not during the off-line scan, so the log stays consistent
            if (wr_en && PADDR_IN == STL_ADDR_CONFIG && state_q != STL_SPANS) begin
                pend_time_q <= PWDATA_IN[15:0];
                scan_en_q   <= PWDATA_IN[16];
            end
            if (wr_en && PADDR_IN == STL_ADDR_MEDIA) begin
                media_done_q <= PWDATA_IN[0];
                media_err_q  <= PWDATA_IN[1];
            end
        end
    end

    // Count register: host value, zero after a good read-log
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN)
            count_reg_q <= 8'h00;
        else if (do_read && !bad_log)
            count_reg_q <= 8'h00;
        else if (wr_en && PADDR_IN == STL_ADDR_TASKFILE)
            count_reg_q <= PWDATA_IN[23:16];
    end

    // Millisecond tick for the resume delay
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN)
            ms_cnt_q <= 32'h0;
        else if (state_q != STL_PENDING || ms_cnt_q == 32'(MS_CYCLES - 1))
            ms_cnt_q <= 32'h0;
        else
            ms_cnt_q <= ms_cnt_q + 32'h1;
    end

    // Test sequencer
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q     <= STL_IDLE;
            boot_q      <= 3'h1;
            st_status_q <= STL_ST_OK;
            ol_status_q <= STL_ST_OK;
            span_q      <= 4'h0;
            pending_q   <= 1'b0;
            active_q    <= 1'b0;
            captive_q   <= 1'b0;
            delay_q     <= 16'h0;
        end else begin
            boot_q <= {boot_q[1:0], 1'b0};
            if (boot_now && nvp_s2_q) begin
                // Power returned during an off-line scan: wait, then resume
                state_q     <= STL_PENDING;
                pending_q   <= 1'b1;
                active_q    <= 1'b0;
                span_q      <= STL_SPAN_OFFLINE;
                ol_status_q <= STL_OL_SCANNING;
                delay_q   <= pend_time_q;
            end else if (soft_rise && state_q == STL_SPANS && !pending_q) begin
                state_q     <= STL_IDLE;
                st_status_q <= STL_ST_ABORTED;
                captive_q   <= 1'b0;
            end else if (do_exec && sector_number_reg_q == STL_SUB_ABORT) begin
                state_q     <= STL_IDLE;
                st_status_q <= STL_ST_ABORTED;
                pending_q   <= 1'b0;
                active_q    <= 1'b0;
            end else if (do_exec && is_test) begin
                // Any running test is dropped for the new request
                state_q     <= is_sel ? STL_SPANS : STL_SHORTEXT;
                st_status_q <= STL_ST_RUNNING;
                captive_q   <= is_capt;
                span_q      <= 4'h1;
                pending_q   <= 1'b0;
                active_q    <= 1'b0;
            end else if (do_exec && sector_number_reg_q == STL_SUB_OFFLINE) begin
                state_q     <= STL_COLLECT;
                ol_status_q <= STL_ST_RUNNING;
            end else begin
                case (state_q)
                    STL_SHORTEXT: if (media_done_q || media_err_q) begin
                        state_q     <= STL_IDLE;
                        st_status_q <= media_err_q ? STL_ST_FAILED : STL_ST_OK;
                        captive_q   <= 1'b0;
                    end
                    STL_COLLECT: if (media_done_q) begin
                        state_q     <= STL_IDLE;
                        ol_status_q <= STL_OL_DONE;
                    end
                    STL_SPANS: if (media_err_q) begin
                        state_q     <= STL_IDLE;
                        st_status_q <= STL_ST_FAILED;
                        captive_q   <= 1'b0;
                    end else if (media_done_q) begin
                        if (span_q != STL_SPAN_COUNT)
                            span_q <= span_q + 4'h1;
                        else if (scan_en_q) begin
                            state_q     <= STL_OFFSCAN;
                            pending_q   <= 1'b1;
                            active_q    <= 1'b1;
                            span_q      <= STL_SPAN_OFFLINE;
                            st_status_q <= STL_ST_OK;
                            ol_status_q <= STL_OL_SCANNING;
                            captive_q   <= 1'b0;
                        end else begin
                            state_q     <= STL_IDLE;
                            st_status_q <= STL_ST_OK;
                            captive_q   <= 1'b0;
                        end
                    end
                    STL_PENDING: if (delay_q == 16'h0) begin
                        state_q  <= STL_OFFSCAN;
                        active_q <= 1'b1;
                    end else if (ms_cnt_q == 32'(MS_CYCLES - 1))
                        delay_q <= delay_q - 16'h1;
                    // Media errors are only logged by the drive, never reported here
                    STL_OFFSCAN: if (media_done_q) begin
                        state_q     <= STL_IDLE;
                        pending_q   <= 1'b0;
                        active_q    <= 1'b0;
                        ol_status_q <= STL_OL_DONE;
                    end
                    STL_IDLE: ;
                    default: state_q <= STL_IDLE;
                endcase
            end
        end
    end

    // Busy, interrupt and abort: captive tests hold busy until the outcome is stored
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            busy_q  <= 1'b0;
            intrq_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (cmd_wr) begin
            busy_q  <= do_exec && is_test && is_capt;
            intrq_q <= !(do_exec && is_test && is_capt);
            abort_q <= !smart_ok || (do_read && bad_log) || !(do_exec || do_read);
        end else if (busy_q && !captive_q) begin
            busy_q  <= 1'b0;
            intrq_q <= 1'b1;
        end else if (rd_en && PADDR_IN == STL_ADDR_STATUS)
            intrq_q <= 1'b0;
    end

    // Log transfer always starts at the first sector of the named log
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            log_addr_q <= STL_LOG_DIR;
            word_idx_q <= 7'h0;
        end else if (do_read) begin
            log_addr_q <= sector_number_reg_q;
            word_idx_q <= 7'h0;
        end else if (data_rd)
            word_idx_q <= word_idx_q + 7'h1;
    end

    // APB read data; zero-wait answers, unmapped reads return zero with error
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT  <= 32'h0;
            PSLVERR_OUT <= 1'b0;
            PREADY_OUT  <= 1'b0;
        end else begin
            PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & (PADDR_IN > STL_ADDR_DATA || PADDR_IN[1:0] != 2'b00);
            PRDATA_OUT  <= 32'h0;
            if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
                case (PADDR_IN)
                    STL_ADDR_TASKFILE: PRDATA_OUT <= {8'h00, count_reg_q, sector_number_reg_q, features_reg_q};
                    STL_ADDR_TRACK:    PRDATA_OUT <= {16'h0, track_address_pair_q};
                    STL_ADDR_STATUS:   PRDATA_OUT <= {26'h0, active_q, pending_q, abort_q, intrq_q, captive_q, busy_q};
                    STL_ADDR_RESULTS:  PRDATA_OUT <= {8'h00, 4'h0, span_q, ol_status_q, st_status_q};
                    STL_ADDR_CONFIG:   PRDATA_OUT <= {15'h0, scan_en_q, pend_time_q};
                    STL_ADDR_DATA: begin
                        if (log_addr_q == STL_LOG_DIR)
                            PRDATA_OUT <= dir_word(word_idx_q);
                        else if (log_addr_q == STL_LOG_SELECTIVE && word_idx_q == 7'h0)
                            PRDATA_OUT <= {16'h0, 4'h0, span_q, 6'h0, active_q, pending_q};
                    end
                    default: PRDATA_OUT <= 32'h0;
                endcase
            end
        end
    end

    // Outputs straight from flops
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            BUSY_OUT       <= 1'b0;
            INTRQ_OUT      <= 1'b0;
            NV_PENDING_OUT <= 1'b0;
            NV_ACTIVE_OUT  <= 1'b0;
        end else begin
            BUSY_OUT       <= busy_q;
            INTRQ_OUT      <= intrq_q;
            NV_PENDING_OUT <= pending_q;
            NV_ACTIVE_OUT  <= active_q;
        end
    end

    chk_scan_flags: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        state_q == STL_OFFSCAN |-> pending_q && active_q && span_q == STL_SPAN_OFFLINE)
        else $error("off-line scan without flags");
    chk_scan_end: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        state_q == STL_OFFSCAN && media_done_q |=> !pending_q && !active_q && ol_status_q == STL_OL_DONE)
        else $error("scan end flags wrong");
    chk_pend_hold: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        state_q == STL_PENDING |-> pending_q && !active_q)
        else $error("pending state flags wrong");
    chk_span_error: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        state_q == STL_SPANS && media_err_q && !do_exec && !soft_rise && !boot_now
        |=> state_q == STL_IDLE && st_status_q == STL_ST_FAILED)
        else $error("span error not reported");
    chk_abort_sub: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        do_exec && sector_number_reg_q == STL_SUB_ABORT && !boot_now |=> state_q == STL_IDLE)
        else $error("abort subcommand ignored");
    chk_bad_log: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        do_read && bad_log |=> abort_q ##1 abort_q)
        else $error("bad log not aborted");
    chk_count_zero: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        do_read && !bad_log |=> count_reg_q == 8'h00)
        else $error("count not zero after read log");
    chk_capt_busy: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        busy_q && !captive_q |=> !busy_q && intrq_q)
        else $error("busy left after completion");
endmodule

//--- sim/stl_nv_model.sv
// Non-volatile flag store beside the unit, kept across device resets
`timescale 1ns/100ps
module stl_nv_model (
    input  wire logic CLOCK_IN,
    input  wire logic RST_IN,
    input  wire logic PENDING_IN,
    input  wire logic ACTIVE_IN,
    output logic      PENDING_OUT = 1'b0,
    output logic      ACTIVE_OUT = 1'b0
);
    logic [3:0] hold_q = 4'hf;
    // Writes wait until the unit has reloaded the flags, else its cleared outputs wipe the store
    always @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            hold_q <= 4'hf;
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end else begin
            PENDING_OUT <= PENDING_IN;
            ACTIVE_OUT  <= ACTIVE_IN;
        end
    end
endmodule

//--- sim/tb_top.sv
// Testbench: APB host driving the self-test and log read unit
`timescale 1ns/100ps
module tb_top;
    import stl_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, srst = 0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0, rdata, rnd = 32'd37;
    logic        rdy, err, nvp_o, nva_o, nvp_i, nva_i, busy, irq;
    logic [64:0] exp_q[$];
    int          miscompares = 0, n_tests = 0;
    always #5 clk = ~clk;
    stl_unit #(.MS_CYCLES(10)) uut (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(rdata), .PREADY_OUT(rdy),
        .PSLVERR_OUT(err), .SOFT_RESET_IN(srst), .NV_PENDING_IN(nvp_i), .NV_ACTIVE_IN(nva_i),
        .NV_PENDING_OUT(nvp_o), .NV_ACTIVE_OUT(nva_o), .BUSY_OUT(busy), .INTRQ_OUT(irq));
    stl_nv_model nv (.CLOCK_IN(clk), .RST_IN(rst), .PENDING_IN(nvp_o), .ACTIVE_IN(nva_o),
        .PENDING_OUT(nvp_i), .ACTIVE_OUT(nva_i));
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    function automatic logic [7:0] cnt(input int k);
        if (k == 0 || k == 6 || k == 9) return 8'h01;
        if (k >= 128 && k <= 159) return 8'h10;
        return 8'h00;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e, input logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        if (!w) exp_q.push_back({er, m, e});
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic er = 1'b0);
        apb(1'b0, a, 32'h0, m, e, er);
    endtask
    task automatic cmd(input logic [7:0] ft, sn);
        logic [31:0] r;
        r = xs();
        wr(STL_ADDR_TRACK, 32'h0000c24f);
        wr(STL_ADDR_TASKFILE, {8'h00, r[7:0], sn, ft});
        wr(STL_ADDR_COMMAND, 32'h000000b0);
    endtask
    task automatic cmp_data(input logic [31:0] m, e);
        n_tests++;
        if ((rdata & m) !== e) begin
            miscompares++;
            $display("mismatch PRDATA expected %h seen %h", e, rdata & m);
        end
    endtask
    task automatic cmp_err(input logic e);
        n_tests++;
        if (err !== e) begin
            miscompares++;
            $display("mismatch PSLVERR expected %b seen %b", e, err);
        end
    endtask
    task automatic cmp_pins(input logic [3:0] m, e);
        n_tests++;
        if (({busy, irq, nvp_o, nva_o} & m) !== e) begin
            miscompares++;
            $display("mismatch pins expected %b seen %b", e, {busy, irq, nvp_o, nva_o} & m);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Oldest note pairs with the read completing at this edge
    always @(posedge clk) begin
        if (psel && pen && rdy === 1'b1 && !pwr) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("mismatch read_queue expected note seen none");
            end else begin
                cmp_data(exp_q[0][63:32], exp_q[0][31:0]);
                cmp_err(exp_q[0][64]);
                void'(exp_q.pop_front());
            end
        end
    end
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        int i;
        logic [31:0] r;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cmd(STL_FT_READ_LOG, 8'h00);
        for (i = 0; i < 80; i++) rd(STL_ADDR_DATA, 32'hffffffff, {8'h00, cnt(2*i+1), 8'h00, cnt(2*i)});
        rd(STL_ADDR_TASKFILE, 32'h00ff0000, 32'h0);
        cmd(STL_FT_READ_LOG, 8'h03);
        rd(STL_ADDR_STATUS, 32'h8, 32'h8);
        cmd(STL_FT_READ_LOG, 8'h07);
        rd(STL_ADDR_STATUS, 32'h8, 32'h8);
        cmd(STL_FT_EXEC, 8'h81);
        rd(STL_ADDR_STATUS, 32'h3, 32'h3);
        cmp_pins(4'b1000, 4'b1000);
        wr(STL_ADDR_MEDIA, 32'h1);
        @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
        cmp_pins(4'b1100, 4'b0100);
        rd(STL_ADDR_STATUS, 32'h5, 32'h4);
        rd(STL_ADDR_RESULTS, 32'hff, 32'h00);
        cmd(STL_FT_EXEC, 8'h82);
        wr(STL_ADDR_MEDIA, 32'h2);
        rd(STL_ADDR_RESULTS, 32'hff, 32'h70);
        cmd(STL_FT_EXEC, 8'h04);
        rd(STL_ADDR_STATUS, 32'h5, 32'h4);
        rd(STL_ADDR_RESULTS, 32'hff, 32'hf0);
        wr(STL_ADDR_MEDIA, 32'h1);
        cmd(STL_FT_EXEC, 8'h0f);
        rd(STL_ADDR_RESULTS, 32'hff, 32'h10);
        cmd(STL_FT_EXEC, 8'h04);
        cmd(STL_FT_EXEC, 8'h81);
        rd(STL_ADDR_STATUS, 32'h3, 32'h3);
        wr(STL_ADDR_MEDIA, 32'h1);
        cmd(STL_FT_EXEC, 8'h04);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(STL_ADDR_RESULTS, 32'hff, 32'h10);
        wr(STL_ADDR_CONFIG, 32'h00010000);
        cmd(STL_FT_EXEC, 8'h04);
        for (i = 0; i < 5; i++) wr(STL_ADDR_MEDIA, 32'h1);
        rd(STL_ADDR_RESULTS, 32'h000fffff, 32'h00060300);
        rd(STL_ADDR_STATUS, 32'h30, 32'h30);
        cmp_pins(4'b0011, 4'b0011);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(STL_ADDR_STATUS, 32'h10, 32'h10);
        repeat (20) @(posedge clk);
        wr(STL_ADDR_MEDIA, 32'h1);
        rd(STL_ADDR_STATUS, 32'h30, 32'h0);
        rd(STL_ADDR_RESULTS, 32'hff00, 32'h0200);
        cmp_pins(4'b0011, 4'b0000);
        cmd(STL_FT_EXEC, 8'h04);
        wr(STL_ADDR_MEDIA, 32'h2);
        rd(STL_ADDR_RESULTS, 32'hff, 32'h70);
        rd(STL_ADDR_STATUS, 32'h30, 32'h0);
        cmd(STL_FT_EXEC, 8'h00);
        rd(STL_ADDR_RESULTS, 32'hff00, 32'hf000);
        wr(STL_ADDR_MEDIA, 32'h1);
        rd(STL_ADDR_RESULTS, 32'hff00, 32'h0200);
        r = xs();
        wr(8'h20, r);
        rd(8'h20, 32'hffffffff, 32'h0, 1'b1);
        repeat (4) @(posedge clk);
        results();
    end
endmodule
